/* hw/pcicc_pkg.sv */
// Constants shared by the PCI command control slice
package pcicc_pkg;

   // ****************************************************************
   // Configuration space offsets
   // ****************************************************************
   localparam logic [7:0]  PCICC_CMD_OFFSET     = 8'h04;

   // ****************************************************************
   // Command field positions
   // ****************************************************************
   localparam int          PCICC_SYS_ERR_EN_BIT = 8;
   localparam int          PCICC_STEP_BIT       = 7;
   localparam int          PCICC_PAR_RESP_BIT   = 6;
   localparam int          PCICC_SNOOP_BIT      = 5;
   localparam int          PCICC_MWI_BIT        = 4;
   localparam int          PCICC_SPECIAL_BIT    = 3;
   localparam int          PCICC_BME_BIT        = 2;

   // ****************************************************************
   // Status field positions (upper half of the dword)
   // ****************************************************************
   localparam int          PCICC_DET_PAR_BIT    = 15;
   localparam int          PCICC_SSE_BIT        = 14;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic        PCICC_SYS_ERR_EN_RST = 1'b0;
   localparam logic        PCICC_PAR_RESP_RST   = 1'b0;
   localparam logic        PCICC_SNOOP_RST      = 1'b0;
   localparam logic        PCICC_MWI_RST        = 1'b0;
   localparam logic        PCICC_SPECIAL_RST    = 1'b0;
   localparam logic        PCICC_BME_RST        = 1'b0;
   localparam logic        PCICC_STEP_RST_BOTH  = 1'b1;

   // ****************************************************************
   // Stepping capability and master command codes
   // ****************************************************************
   localparam int          PCICC_STEP_NEVER     = 0;
   localparam int          PCICC_STEP_ALWAYS    = 1;
   localparam int          PCICC_STEP_EITHER    = 2;
   localparam logic [3:0]  PCICC_CMD_MEM_WRITE  = 4'h7;
   localparam logic [3:0]  PCICC_CMD_MWI        = 4'hf;

endpackage : pcicc_pkg

/* hw/pcicc_cfg_bit.sv */
// One configuration control bit with selectable write access and reset value
`timescale 1ns/1ps
`default_nettype none

module pcicc_cfg_bit #(
   parameter bit WRITABLE  = 1'b1,
   parameter bit RESET_VAL = 1'b0
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic wr_en,
   input  wire logic wr_data,
   output logic      value
);

   // Read-only bits hold their reset value for ever
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         value <= RESET_VAL;
      end else if (WRITABLE && wr_en) begin
         value <= wr_data;
      end
   end

endmodule : pcicc_cfg_bit

`default_nettype wire

/* hw/pcicc_parity_gen.sv */
// Even parity over the driven address/data and byte enables
`timescale 1ns/1ps
`default_nettype none

module pcicc_parity_gen (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [31:0] ad_out,
   input  wire logic [3:0]  cbe_out_n,
   input  wire logic        ad_oe,
   output logic            par_out,
   output logic            par_oe
);

   wire logic next_par;

   assign next_par = ^{ad_out, cbe_out_n};

   // Parity follows the driven phase by one clock, never gated by checking
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         par_out <= 1'b0;
         par_oe  <= 1'b0;
      end else begin
         par_out <= next_par;
         par_oe  <= ad_oe;
      end
   end

endmodule : pcicc_parity_gen

`default_nettype wire

/* hw/pcicc_command_ctrl.sv */
// Command register control bits of the PCI function and the logic they gate
// Summary of operation
// R1 - System error enable set lets the SERR# driver operate.
// R2 - Never-stepping device keeps stepping bit clear; always-stepping keeps it set.
// R3 - Optional-stepping device makes stepping bit writable, resetting to one.
// R4 - Parity response set: normal parity error action on detection.
// R5 - Parity response clear: set detected flag only, no PERR#, keep running.
// R6 - Parity response bit resets to zero.
// R7 - Parity always generated on driven cycles, whatever checking says.
// R8 - Snoop clear: palette writes handled like any other access.
// R9 - Snoop set: palette writes not claimed, their data snooped.
// R10 - Write-invalidate clear: plain memory writes only; resets to zero.
// R11 - Write-invalidate set: master may issue write-and-invalidate.
// R12 - Special cycle bit clear: ignore special cycles; resets to zero.
// R13 - Special cycle bit set: observe special cycles.
// R14 - Bus master clear: initiate nothing; resets to zero.
// R15 - Bus master set: may arbitrate and initiate.
// R16 - Address parity errors go to SERR# only with both enables set.
// R17 - System error enable clear keeps SERR# driver off.
// R18 - Software programs these bits by configuration writes before use.
`timescale 1ns/1ps
`default_nettype none

module pcicc_command_ctrl
   import pcicc_pkg::*;
#(
   parameter int STEP_MODE     = PCICC_STEP_NEVER,
   parameter bit SNOOP_IMPL    = 1'b1,
   parameter bit SPECIAL_IMPL  = 1'b1
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Configuration access from the target engine
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic [31:0]      cfg_rdata,
   output logic             cfg_rd_valid,
   // Parity checker events
   input  wire logic        data_parity_err,
   input  wire logic        addr_parity_err,
   output logic             perr_out_n,
   output logic             perr_oe,
   output logic             serr_out_n,
   output logic             serr_oe,
   output logic             serr_driver_enable,
   output logic             detected_parity_error,
   // Master engine
   input  wire logic        master_req,
   input  wire logic        master_wants_mwi,
   output logic             req_out_n,
   output logic             master_enable,
   output logic [3:0]       master_write_cmd,
   // Palette write detection
   input  wire logic        palette_wr_hit,
   input  wire logic [31:0] palette_wr_data,
   output logic             palette_claim,
   output logic             palette_snoop_valid,
   output logic [31:0]      palette_snoop_data,
   // Special cycle observation
   input  wire logic        special_cycle_seen,
   input  wire logic [15:0] special_cycle_msg,
   output logic             special_msg_valid,
   output logic [15:0]      special_msg,
   // Parity generation for driven phases
   input  wire logic [31:0] ad_out,
   input  wire logic [3:0]  cbe_out_n,
   input  wire logic        ad_oe,
   output logic             par_out,
   output logic             par_oe
);

   // ****************************************************************
   // Decode
   // ****************************************************************
   wire logic        cmd_hit;
   wire logic        wr_byte0;
   wire logic        wr_byte1;
   wire logic        clr_byte3;
   wire logic        system_error_drive_enable;
   wire logic        stepping_control;
   wire logic        parity_error_response;
   wire logic        palette_snoop_enable;
   wire logic        write_invalidate_enable;
   wire logic        special_cycle_monitor;
   wire logic        bus_master_enable;
   wire logic [15:0] cmd_word;
   wire logic [15:0] status_word;
   wire logic        perr_fire;
   wire logic        serr_fire;
   wire logic        next_det_par;
   wire logic        next_sse;
   wire logic [31:0] next_rdata;
   logic             signaled_system_error;

   assign cmd_hit   = (cfg_addr == PCICC_CMD_OFFSET);
   assign wr_byte0  = cfg_wr && cmd_hit && cfg_be[0];
   assign wr_byte1  = cfg_wr && cmd_hit && cfg_be[1];
   assign clr_byte3 = cfg_wr && cmd_hit && cfg_be[3];

   // ****************************************************************
   // Command bits
   // ****************************************************************
   pcicc_cfg_bit #(
      .WRITABLE  (1'b1),
      .RESET_VAL (PCICC_SYS_ERR_EN_RST)
   ) u_sys_err_en (
      .clk     (clk),
      .reset_n (reset_n),
      .wr_en   (wr_byte1),
      .wr_data (cfg_wdata[PCICC_SYS_ERR_EN_BIT]),
      .value   (system_error_drive_enable)
   );

   pcicc_cfg_bit #(
      .WRITABLE  (STEP_MODE == PCICC_STEP_EITHER),                  // R3
      .RESET_VAL ((STEP_MODE == PCICC_STEP_NEVER) ? 1'b0 :
                  PCICC_STEP_RST_BOTH)                              // R2
   ) u_step (
      .clk     (clk),
      .reset_n (reset_n),
      .wr_en   (wr_byte0),
      .wr_data (cfg_wdata[PCICC_STEP_BIT]),
      .value   (stepping_control)
   );

   pcicc_cfg_bit #(
      .WRITABLE  (1'b1),
      .RESET_VAL (PCICC_PAR_RESP_RST)                                // R6
   ) u_par_resp (
      .clk     (clk),
      .reset_n (reset_n),
      .wr_en   (wr_byte0),
      .wr_data (cfg_wdata[PCICC_PAR_RESP_BIT]),
      .value   (parity_error_response)
   );

   pcicc_cfg_bit #(
      .WRITABLE  (SNOOP_IMPL),
      .RESET_VAL (PCICC_SNOOP_RST)
   ) u_snoop (
      .clk     (clk),
      .reset_n (reset_n),
      .wr_en   (wr_byte0),
      .wr_data (cfg_wdata[PCICC_SNOOP_BIT]),
      .value   (palette_snoop_enable)
   );

   pcicc_cfg_bit #(
      .WRITABLE  (1'b1),
      .RESET_VAL (PCICC_MWI_RST)                                     // R10
   ) u_mwi (
      .clk     (clk),
      .reset_n (reset_n),
      .wr_en   (wr_byte0),
      .wr_data (cfg_wdata[PCICC_MWI_BIT]),
      .value   (write_invalidate_enable)
   );

   pcicc_cfg_bit #(
      .WRITABLE  (SPECIAL_IMPL),
      .RESET_VAL (PCICC_SPECIAL_RST)                                 // R12
   ) u_special (
      .clk     (clk),
      .reset_n (reset_n),
      .wr_en   (wr_byte0),
      .wr_data (cfg_wdata[PCICC_SPECIAL_BIT]),
      .value   (special_cycle_monitor)
   );

   pcicc_cfg_bit #(
      .WRITABLE  (1'b1),
      .RESET_VAL (PCICC_BME_RST)                                     // R14
   ) u_bme (
      .clk     (clk),
      .reset_n (reset_n),
      .wr_en   (wr_byte0),
      .wr_data (cfg_wdata[PCICC_BME_BIT]),
      .value   (bus_master_enable)
   );

   // ****************************************************************
   // Read-back
   // ****************************************************************
   assign cmd_word = {7'h00, system_error_drive_enable, stepping_control,
                      parity_error_response, palette_snoop_enable,
                      write_invalidate_enable, special_cycle_monitor,
                      bus_master_enable, 2'h0};
   assign status_word = {detected_parity_error, signaled_system_error, 14'h0000};
   assign next_rdata  = cmd_hit ? {status_word, cmd_word} : 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cfg_rdata    <= 32'h0000_0000;
         cfg_rd_valid <= 1'b0;
      end else begin
         cfg_rd_valid <= cfg_rd;
         if (cfg_rd) begin
            cfg_rdata <= next_rdata;
         end
      end
   end

   // ****************************************************************
   // Parity error handling
   // ****************************************************************
   // Detection is always recorded; signalling depends on the enables
   assign perr_fire = data_parity_err && parity_error_response;                 // R4 R5
   assign serr_fire = addr_parity_err && parity_error_response &&
                      system_error_drive_enable;                                // R16
   // A new event in the clearing cycle wins over the clear
   assign next_det_par = (data_parity_err || addr_parity_err) ||
                         (detected_parity_error &&
                          !(clr_byte3 && cfg_wdata[PCICC_DET_PAR_BIT + 16]));   // R5
   assign next_sse  = serr_fire ||
                      (signaled_system_error &&
                       !(clr_byte3 && cfg_wdata[PCICC_SSE_BIT + 16]));

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         detected_parity_error <= 1'b0;
         signaled_system_error <= 1'b0;
      end else begin
         detected_parity_error <= next_det_par;
         signaled_system_error <= next_sse;
      end
   end

   // Open-drain pins: low while signalling, released otherwise
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         perr_out_n         <= 1'b1;
         perr_oe            <= 1'b0;
         serr_out_n         <= 1'b1;
         serr_oe            <= 1'b0;
         serr_driver_enable <= 1'b0;
      end else begin
         perr_out_n         <= !perr_fire;                                      // R4
         perr_oe            <= perr_fire;                                       // R5
         serr_out_n         <= !serr_fire;
         serr_oe            <= serr_fire && system_error_drive_enable;          // R1 R17
         serr_driver_enable <= system_error_drive_enable;                       // R1 R17
      end
   end

   // ****************************************************************
   // Master gating
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         req_out_n        <= 1'b1;
         master_enable    <= 1'b0;
         master_write_cmd <= PCICC_CMD_MEM_WRITE;
      end else begin
         req_out_n        <= !(master_req && bus_master_enable);                // R14 R15
         master_enable    <= bus_master_enable;                                 // R14 R15
         master_write_cmd <= (master_wants_mwi && write_invalidate_enable) ?
                             PCICC_CMD_MWI : PCICC_CMD_MEM_WRITE;               // R10 R11
      end
   end

   // ****************************************************************
   // Palette snooping and special cycles
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         palette_claim       <= 1'b0;
         palette_snoop_valid <= 1'b0;
         palette_snoop_data  <= 32'h0000_0000;
      end else begin
         palette_claim       <= palette_wr_hit && !palette_snoop_enable;        // R8 R9
         palette_snoop_valid <= palette_wr_hit && palette_snoop_enable;         // R9
         if (palette_wr_hit && palette_snoop_enable) begin
            palette_snoop_data <= palette_wr_data;                              // R9
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         special_msg_valid <= 1'b0;
         special_msg       <= 16'h0000;
      end else begin
         special_msg_valid <= special_cycle_seen && special_cycle_monitor;      // R12 R13
         if (special_cycle_seen && special_cycle_monitor) begin
            special_msg <= special_cycle_msg;                                   // R13
         end
      end
   end

   // ****************************************************************
   // Parity generation
   // ****************************************************************
   pcicc_parity_gen u_par (                                                     // R7
      .clk       (clk),
      .reset_n   (reset_n),
      .ad_out    (ad_out),
      .cbe_out_n (cbe_out_n),
      .ad_oe     (ad_oe),
      .par_out   (par_out),
      .par_oe    (par_oe)
   );

endmodule : pcicc_command_ctrl

`default_nettype wire

/* test/pcicc_command_ctrl_sva.sv */
// Port assertions for the command control slice
`timescale 1ns/1ps
`default_nettype none
module pcicc_command_ctrl_sva
   import pcicc_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        data_parity_err,
   input wire logic        addr_parity_err,
   input wire logic        perr_out_n,
   input wire logic        perr_oe,
   input wire logic        serr_out_n,
   input wire logic        serr_oe,
   input wire logic        serr_driver_enable,
   input wire logic        detected_parity_error,
   input wire logic        master_req,
   input wire logic        master_wants_mwi,
   input wire logic        req_out_n,
   input wire logic        master_enable,
   input wire logic [3:0]  master_write_cmd,
   input wire logic        palette_wr_hit,
   input wire logic        palette_claim,
   input wire logic        palette_snoop_valid,
   input wire logic        special_cycle_seen,
   input wire logic [15:0] special_cycle_msg,
   input wire logic        special_msg_valid,
   input wire logic [15:0] special_msg,
   input wire logic [31:0] ad_out,
   input wire logic [3:0]  cbe_out_n,
   input wire logic        ad_oe,
   input wire logic        par_out,
   input wire logic        par_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ****************************************************************
   // Master enable sequences
   // ****************************************************************
   sequence s_master_on; master_req && master_enable ##1 master_enable; endsequence
   sequence s_master_off; !master_enable ##1 !master_enable; endsequence
   property p_serr; serr_oe |-> $past(addr_parity_err) && !serr_out_n && serr_driver_enable; endproperty
   a_serr: assert property (p_serr) else $error("serr without cause");
   property p_perr; perr_oe |-> $past(data_parity_err) && !perr_out_n; endproperty
   a_perr: assert property (p_perr) else $error("perr without cause");
   property p_dpe; data_parity_err || addr_parity_err |=> detected_parity_error; endproperty
   a_dpe: assert property (p_dpe) else $error("status flag not set");
   property p_master_on; s_master_on |-> !req_out_n; endproperty
   a_master_on: assert property (p_master_on) else $error("request missing");
   property p_master_off; s_master_off |-> req_out_n; endproperty
   a_master_off: assert property (p_master_off) else $error("request while disabled");
   property p_mwi; master_write_cmd == PCICC_CMD_MWI |-> $past(master_wants_mwi); endproperty
   a_mwi: assert property (p_mwi) else $error("unasked invalidate");
   property p_pal; palette_wr_hit |=> palette_claim != palette_snoop_valid; endproperty
   a_pal: assert property (p_pal) else $error("palette write mishandled");
   property p_spec; special_msg_valid |-> $past(special_cycle_seen) && special_msg == $past(special_cycle_msg); endproperty
   a_spec: assert property (p_spec) else $error("special message wrong");
   property p_par; par_oe |-> $past(ad_oe) && par_out == ^{$past(ad_out), $past(cbe_out_n)}; endproperty
   a_par: assert property (p_par) else $error("parity wrong");
endmodule : pcicc_command_ctrl_sva
`default_nettype wire

/* test/pcicc_host_model.sv */
// Configuration software model issuing config cycles
`timescale 1ns/1ps
`default_nettype none
module pcicc_host_model (
   input  wire logic  clk,
   output logic       cfg_wr,
   output logic       cfg_rd,
   output logic [7:0] cfg_addr,
   output logic [3:0] cfg_be,
   output logic [31:0] cfg_wdata
);
   initial begin
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = 8'hff;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0000_0000;
   end
   // Bits are only programmed through config cycles; released lines show inverse
   task automatic cfg_write(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] d);
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_addr <= addr;
      cfg_be <= be;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
      cfg_addr <= ~addr;
      cfg_be <= ~be;
      cfg_wdata <= ~d;
   endtask : cfg_write
   task automatic cfg_read(input logic [7:0] addr);
      @(posedge clk);
      cfg_rd <= 1'b1;
      cfg_addr <= addr;
      @(posedge clk);
      cfg_rd <= 1'b0;
      cfg_addr <= ~addr;
   endtask : cfg_read
endmodule : pcicc_host_model
`default_nettype wire

/* test/pcicc_command_ctrl_tb_top.sv */
// Self-checking bench for the command control slice
`timescale 1ns/1ps
`default_nettype none
module pcicc_command_ctrl_tb_top;
   import pcicc_pkg::*;
   logic clk, reset_n, data_parity_err, addr_parity_err, master_req, master_wants_mwi;
   logic palette_wr_hit, special_cycle_seen, ad_oe, cfg_wr, cfg_rd, cfg_rd_valid;
   logic perr_out_n, perr_oe, serr_out_n, serr_oe, serr_driver_enable, req_out_n;
   logic detected_parity_error, master_enable, palette_claim, palette_snoop_valid;
   logic special_msg_valid, par_out, par_oe;
   logic [31:0] palette_wr_data, ad_out, cfg_wdata, cfg_rdata, palette_snoop_data, w, a;
   logic [15:0] special_cycle_msg, special_msg;
   logic [7:0] cfg_addr;
   logic [3:0] cbe_out_n, cfg_be, master_write_cmd, c;
   logic [31:0] rd_q[$];
   logic [38:0] ev_q[$];
   int mismatches, n_compared, cycles, k;
   wire logic [38:0] ev_now = {perr_oe, ~perr_out_n, serr_oe, ~serr_out_n, palette_claim,
      palette_snoop_valid, special_msg_valid, palette_snoop_valid ? palette_snoop_data :
      special_msg_valid ? {16'h0000, special_msg} : 32'h0000_0000};
   pcicc_command_ctrl #(.STEP_MODE(PCICC_STEP_EITHER), .SNOOP_IMPL(1'b1),
      .SPECIAL_IMPL(1'b1)) dut_u (.*);
   pcicc_host_model host_u (.*);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input logic [38:0] seen, input logic [38:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   task automatic pulse_err(input logic d, input logic e);
      @(posedge clk);
      data_parity_err <= d;
      addr_parity_err <= e;
      @(posedge clk);
      data_parity_err <= 1'b0;
      addr_parity_err <= 1'b0;
   endtask : pulse_err
   // ****************************************************************
   // Output monitor and timeout
   // ****************************************************************
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         finish_test();
      end
      if (reset_n === 1'b1 && cfg_rd_valid !== 1'b0)
         check(cfg_rdata, (rd_q.size() > 0) ? rd_q.pop_front() : 'x);
      if (reset_n === 1'b1 && ev_now[38:32] !== 7'h00)
         check(ev_now, (ev_q.size() > 0) ? ev_q.pop_front() : 'x);
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      void'($urandom(547));
      {reset_n, data_parity_err, addr_parity_err, master_req, master_wants_mwi} = 5'h00;
      {palette_wr_hit, special_cycle_seen, ad_oe, cbe_out_n} = 7'h00;
      {palette_wr_data, ad_out, special_cycle_msg} = 80'h0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      rd_q.push_back(32'h0000_0080);
      host_u.cfg_read(8'h04);
      check(req_out_n, 1'b1);
      check(master_write_cmd, PCICC_CMD_MEM_WRITE);
      for (k = 0; k < 6; k++) begin
         w = $urandom();
         host_u.cfg_write(8'h04, 4'b0011, w);
         rd_q.push_back({23'h0, w[8:2], 2'b00});
         host_u.cfg_read(8'h04);
      end
      host_u.cfg_write(8'h08, 4'hf, 32'hffff_ffff);
      rd_q.push_back(32'h0000_0000);
      host_u.cfg_read(8'h08);
      rd_q.push_back({23'h0, w[8:2], 2'b00});
      host_u.cfg_read(8'h04);
      for (k = 0; k < 5; k++) begin
         host_u.cfg_write(8'h04, 4'b1011, {8'hc0, 15'h0, k[1], 1'b0, k[0], 6'h00});
         if (k == 4)
            break;
         repeat (2) @(posedge clk);
         if (k[0])
            ev_q.push_back({7'b1100000, 32'h0});
         pulse_err(1'b1, 1'b0);
         if (k == 3)
            ev_q.push_back({7'b0011000, 32'h0});
         pulse_err(1'b0, 1'b1);
         @(posedge clk);
         check(detected_parity_error, 1'b1);
         check(serr_driver_enable, k[1]);
         rd_q.push_back({1'b1, k == 3, 21'h0, k[1], 1'b0, k[0], 6'h00});
         host_u.cfg_read(8'h04);
      end
      for (k = 0; k < 8; k++) begin
         host_u.cfg_write(8'h04, 4'b0011, {26'h0, k[0], 1'b0, k[1], 3'b000});
         repeat (2) @(posedge clk);
         w = $urandom();
         ev_q.push_back(k[0] ? {7'b0000010, w} : {7'b0000100, 32'h0});
         @(posedge clk);
         palette_wr_hit <= 1'b1;
         palette_wr_data <= w;
         @(posedge clk);
         palette_wr_hit <= 1'b0;
         palette_wr_data <= ~w;
         special_cycle_seen <= w[0];
         special_cycle_msg <= w[31:16];
         if (k[1] && w[0])
            ev_q.push_back({7'b0000001, 16'h0000, w[31:16]});
         @(posedge clk);
         special_cycle_seen <= 1'b0;
         special_cycle_msg <= ~w[31:16];
      end
      for (k = 0; k < 8; k++) begin
         w = $urandom();
         master_req <= w[0];
         master_wants_mwi <= w[1];
         host_u.cfg_write(8'h04, 4'b0011, {27'h0, k[1], 1'b0, k[0], 2'b00});
         repeat (3) @(posedge clk);
         check({req_out_n, master_enable}, {!(k[0] && w[0]), k[0]});
         check(master_write_cmd, (k[1] && w[1]) ? PCICC_CMD_MWI : PCICC_CMD_MEM_WRITE);
      end
      for (k = 0; k < 4; k++) begin
         a = $urandom();
         c = 4'($urandom());
         @(posedge clk);
         ad_out <= a;
         cbe_out_n <= c;
         ad_oe <= a[31];
         @(posedge clk);
         ad_out <= ~a;
         cbe_out_n <= ~c;
         ad_oe <= 1'b0;
         @(posedge clk);
         check({par_oe, par_out}, {a[31], ^{a, c}});
      end
      // Mid-run reset must bring every bit back to its reset value
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      rd_q.push_back(32'h0000_0080);
      host_u.cfg_read(8'h04);
      check(req_out_n, 1'b1);
      check(master_write_cmd, PCICC_CMD_MEM_WRITE);
      repeat (4) @(posedge clk);
      check(39'(ev_q.size() + rd_q.size()), 39'h0);
      finish_test();
   end
endmodule : pcicc_command_ctrl_tb_top
bind pcicc_command_ctrl pcicc_command_ctrl_sva chk_u (.*);
`default_nettype wire
